/* File: design/sxa_alu_top.sv */
// subtract / xor / nibble-swap execution datapath with AXI4-Lite registers
// Notes on behaviour
// [RULE1] literal minus working register into working register
// [RULE2] literal xor working register, only zero flag
// [RULE3] file minus working register, address 0..127
// [RULE4] file xor working register, only zero flag
// [RULE5] nibble swap of file, flags untouched
// [RULE6] dest 0 to working, 1 to file
// [RULE7] carry, digit carry mean no borrow; zero
`timescale 1ns/1ps
module sxa_alu_top
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // data register file port
    output logic [6:0] file_addr,
    input wire logic [7:0] file_rd_data,
    output logic file_wr_en,
    output logic [7:0] file_wr_data
);
    import sxa_pkg::*;

    // ==========================================================
    // state
    typedef enum logic {ST_IDLE, ST_EXEC} sxa_phase_t;

    // all registered state of the datapath
    typedef struct packed {
        sxa_phase_t phase;
        logic [7:0] w_reg;
        sxa_flags_t flags;
        sxa_cmd_t cmd;
        logic [7:0] result;
        logic bad_op;
        logic file_we;
        logic [7:0] file_wdata;
    } sxa_top_t;

    sxa_top_t st_ff;
    sxa_top_t nxt_st;

    // register strobes from the bus front end
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;

    // arithmetic core results
    logic [7:0] alu_res;
    sxa_flags_t alu_flags;
    logic alu_ok;
    logic alu_file_op;
    logic in_exec;

    // ==========================================================
    // bus front end
    sxa_axil_slave u_slv
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // ==========================================================
    // arithmetic core, fed from the held command
    sxa_alu_core u_alu
    (
        .op(st_ff.cmd.op),
        .w_val(st_ff.w_reg),
        .lit(st_ff.cmd.literal),
        .fval(file_rd_data),
        .flags_in(st_ff.flags),
        .res(alu_res),
        .flags_out(alu_flags),
        .op_ok(alu_ok),
        .file_op(alu_file_op)
    );

    assign in_exec = (st_ff.phase == ST_EXEC);

    // ==========================================================
    // address decode and read mux
    always_comb
    begin
        // every printed register answers okay
        wr_ok = (wr_addr == OFS_W_REG) || (wr_addr == OFS_FLAGS) ||
                (wr_addr == OFS_CMD) || (wr_addr == OFS_STATE);
        rd_ok = 1'b1;
        case (rd_addr)
            OFS_W_REG: rd_data = {24'h000000, st_ff.w_reg};
            OFS_FLAGS: rd_data = {29'h00000000, st_ff.flags};
            OFS_CMD: rd_data = {8'h00, st_ff.cmd};
            OFS_STATE: rd_data = {22'h000000, st_ff.bad_op, in_exec, st_ff.result};
            default:
            begin
                // unmapped: zero data, slave error
                rd_data = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // next state: register writes, then execution
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.file_we = 1'b0;
        // software writes
        if (wr_en)
        begin
            case (wr_addr)
                // size casts keep only the low lanes of the merged word
                OFS_W_REG: nxt_st.w_reg = 8'(sxa_merge({24'h000000, st_ff.w_reg}, wr_data, wr_strb));
                OFS_FLAGS: nxt_st.flags = 3'(sxa_merge({29'h00000000, st_ff.flags}, wr_data, wr_strb));
                OFS_CMD:
                begin
                    // a command write launches one execution cycle
                    if (!in_exec)
                    begin
                        nxt_st.cmd = 24'(sxa_merge({8'h00, st_ff.cmd}, wr_data, wr_strb));
                        nxt_st.cmd.pad_hi = 5'h00;
                        nxt_st.phase = ST_EXEC;
                    end
                end
                default:
                begin
                    // status word is read-only
                    nxt_st.phase = st_ff.phase;
                end
            endcase
        end
        // execution of the held command
        if (in_exec)
        begin
            nxt_st.phase = ST_IDLE;
            nxt_st.bad_op = !alu_ok;
            if (alu_ok)
            begin
                nxt_st.result = alu_res;
                nxt_st.flags = alu_flags; // [RULE7]
                if (alu_file_op && st_ff.cmd.dest)
                begin
                    // back into the addressed file register
                    nxt_st.file_we = 1'b1; // [RULE6]
                    nxt_st.file_wdata = alu_res;
                end
                else
                begin
                    // literal ops and dest 0 land in W
                    nxt_st.w_reg = alu_res; // [RULE1] [RULE2] [RULE6]
                end
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_ff <= '{phase: ST_IDLE, w_reg: RST_W_REG, flags: RST_FLAGS, cmd: RST_CMD,
                       result: 8'h00, bad_op: 1'b0, file_we: 1'b0, file_wdata: 8'h00};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // register file port, all from flops
    assign file_addr = st_ff.cmd.faddr; // [RULE3]
    assign file_wr_en = st_ff.file_we;
    assign file_wr_data = st_ff.file_wdata;

    // ==========================================================
    // assertions
    logic [2:0] x_op;
    assign x_op = st_ff.cmd.op;

    property p_sub_lit;
        @(posedge aclk) disable iff (!aresetn)
        in_exec && x_op == 3'h0 |=> st_ff.w_reg == 8'($past(st_ff.cmd.literal) - $past(st_ff.w_reg));
    endproperty
    a_sub_lit: assert property (p_sub_lit) else $error("literal subtract wrong"); // [RULE1]

    property p_xor_lit;
        @(posedge aclk) disable iff (!aresetn)
        in_exec && x_op == 3'h1 |=> st_ff.w_reg == ($past(st_ff.cmd.literal) ^ $past(st_ff.w_reg))
            && st_ff.flags.carry == $past(st_ff.flags.carry);
    endproperty
    a_xor_lit: assert property (p_xor_lit) else $error("literal xor wrong"); // [RULE2]

    property p_sub_file;
        @(posedge aclk) disable iff (!aresetn)
        in_exec && x_op == 3'h2 |=> st_ff.result == 8'($past(file_rd_data) - $past(st_ff.w_reg));
    endproperty
    a_sub_file: assert property (p_sub_file) else $error("file subtract wrong"); // [RULE3]

    property p_xor_file;
        @(posedge aclk) disable iff (!aresetn)
        in_exec && x_op == 3'h3 |=> $stable(st_ff.flags.carry) && $stable(st_ff.flags.digit_carry_flag)
            && st_ff.flags.zero == (st_ff.result == 8'h00);
    endproperty
    a_xor_file: assert property (p_xor_file) else $error("file xor flags wrong"); // [RULE4]

    property p_swap;
        @(posedge aclk) disable iff (!aresetn)
        in_exec && x_op == 3'h4 |=> $stable(st_ff.flags)
            && st_ff.result == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])};
    endproperty
    a_swap: assert property (p_swap) else $error("nibble swap wrong"); // [RULE5]

    property p_dest;
        @(posedge aclk) disable iff (!aresetn)
        in_exec && x_op >= 3'h2 && x_op <= 3'h4 |=>
            (file_wr_en == $past(st_ff.cmd.dest)) && (file_wr_en ? $stable(st_ff.w_reg) : st_ff.w_reg == st_ff.result);
    endproperty
    a_dest: assert property (p_dest) else $error("destination select wrong"); // [RULE6]

    // subtract flags: zero, carry and digit carry all follow the operands
    property p_flags;
        @(posedge aclk) disable iff (!aresetn)
        in_exec && (x_op == 3'h0 || x_op == 3'h2) |=> st_ff.flags.zero == (st_ff.result == 8'h00)
            && st_ff.flags.carry == (st_ff.result <= ($past(x_op) == 3'h0 ? $past(st_ff.cmd.literal)
            : $past(file_rd_data)))
            && st_ff.flags.digit_carry_flag == (($past(x_op) == 3'h0 ? $past(st_ff.cmd.literal[3:0])
            : $past(file_rd_data[3:0])) >= $past(st_ff.w_reg[3:0]));
    endproperty
    a_flags: assert property (p_flags) else $error("subtract flags wrong"); // [RULE7]

    property p_launch;
        @(posedge aclk) disable iff (!aresetn)
        wr_en && wr_addr == OFS_CMD && !in_exec |=> in_exec ##1 !in_exec;
    endproperty
    a_launch: assert property (p_launch) else $error("command did not run once");

    // scenarios worth seeing
    c_sub_file_to_file: cover property (@(posedge aclk) disable iff (!aresetn)
        in_exec && x_op == 3'h2 && st_ff.cmd.dest);
    c_swap_to_w: cover property (@(posedge aclk) disable iff (!aresetn)
        in_exec && x_op == 3'h4 && !st_ff.cmd.dest);
    c_borrow: cover property (@(posedge aclk) disable iff (!aresetn)
        in_exec && x_op == 3'h0 && !alu_flags.carry);
    c_bad_op: cover property (@(posedge aclk) disable iff (!aresetn)
        in_exec && !alu_ok);
    c_xor_zero: cover property (@(posedge aclk) disable iff (!aresetn)
        in_exec && x_op == 3'h3 && alu_res == 8'h00);

endmodule : sxa_alu_top

/* File: design/sxa_pkg.sv */
// shared constants, types and helpers of the subtract/xor/swap datapath
package sxa_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] OFS_W_REG = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_STATE = 8'h0C;

    // ==========================================================
    // field positions
    localparam int FLG_CARRY_BIT = 0;
    localparam int FLG_DC_BIT = 1;
    localparam int FLG_ZERO_BIT = 2;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_DEST_BIT = 3;
    localparam int CMD_ADDR_LSB = 4;
    localparam int CMD_LIT_LSB = 16;
    localparam int ST_BUSY_BIT = 8;
    localparam int ST_BADOP_BIT = 9;

    // ==========================================================
    // reset values and bus answers
    localparam logic [7:0] RST_W_REG = 8'h00;
    localparam logic [2:0] RST_FLAGS = 3'h0;
    localparam logic [23:0] RST_CMD = 24'h000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // operations, codes 0..4 in the command op field
    typedef enum logic [2:0]
    {
        SUB_FROM_LITERAL_OP,
        XOR_LITERAL_OP,
        SUB_FROM_FILE_OP,
        XOR_FILE_OP,
        NIBBLE_SWAP_OP
    } sxa_op_t;

    // status flags, packed at their register positions
    typedef struct packed {
        logic zero;
        logic digit_carry_flag;
        logic carry;
    } sxa_flags_t;

    // one command as it sits in the command register
    typedef struct packed {
        logic [7:0] literal;
        logic [4:0] pad_hi;
        logic [6:0] faddr;
        logic dest;
        logic [2:0] op;
    } sxa_cmd_t;

    // subtraction a - b with no-borrow flags: {carry, digit carry, result}
    function automatic logic [9:0] sxa_sub(logic [7:0] a, logic [7:0] b);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} - {1'b0, b};
        low = {1'b0, a[3:0]} - {1'b0, b[3:0]};
        return {~full[8], ~low[4], full[7:0]};
    endfunction : sxa_sub

    // byte-lane merge of a bus write into an old word
    function automatic logic [31:0] sxa_merge(logic [31:0] old_v, logic [31:0] new_v, logic [3:0] strb);
        logic [31:0] m;
        m = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                m[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return m;
    endfunction : sxa_merge

endpackage : sxa_pkg

/* File: design/sxa_alu_core.sv */
// combinational arithmetic core: result and flag update per operation
`timescale 1ns/1ps
module sxa_alu_core
(
    // operation and operands
    input wire logic [2:0] op,
    input wire logic [7:0] w_val,
    input wire logic [7:0] lit,
    input wire logic [7:0] fval,
    input wire sxa_pkg::sxa_flags_t flags_in,
    // outputs
    output logic [7:0] res,
    output sxa_pkg::sxa_flags_t flags_out,
    output logic op_ok,
    output logic file_op
);
    import sxa_pkg::*;

    // ==========================================================
    // operation decode
    always_comb
    begin
        logic [9:0] d;
        d = 10'h000;
        res = 8'h00;
        flags_out = flags_in;
        op_ok = 1'b1;
        file_op = 1'b0;
        case (op)
            SUB_FROM_LITERAL_OP:
            begin
                // literal minus working register
                d = sxa_sub(lit, w_val); // [RULE1]
                res = d[7:0];
                flags_out = '{zero: d[7:0] == 8'h00, digit_carry_flag: d[8], carry: d[9]}; // [RULE7]
            end
            XOR_LITERAL_OP:
            begin
                // only zero moves
                res = w_val ^ lit; // [RULE2]
                flags_out.zero = (res == 8'h00);
            end
            SUB_FROM_FILE_OP:
            begin
                // file minus working register
                d = sxa_sub(fval, w_val); // [RULE3]
                res = d[7:0];
                flags_out = '{zero: d[7:0] == 8'h00, digit_carry_flag: d[8], carry: d[9]}; // [RULE7]
                file_op = 1'b1;
            end
            XOR_FILE_OP:
            begin
                res = w_val ^ fval; // [RULE4]
                flags_out.zero = (res == 8'h00);
                file_op = 1'b1;
            end
            NIBBLE_SWAP_OP:
            begin
                // exchange nibbles, flags held
                res = {fval[3:0], fval[7:4]}; // [RULE5]
                file_op = 1'b1;
            end
            default:
            begin
                // unknown code: result zero, flags passed through, op_ok low
                op_ok = 1'b0;
            end
        endcase
    end

endmodule : sxa_alu_core

/* File: design/sxa_axil_slave.sv */
// AXI4-Lite slave front end with one-cycle register strobes
`timescale 1ns/1ps
module sxa_axil_slave
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address and data
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // register side
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic rd_en,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    import sxa_pkg::*;

    // all state of the slave
    typedef struct packed {
        logic aw_held;
        logic w_held;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } sxa_slv_t;

    sxa_slv_t st_ff;
    sxa_slv_t nxt_st;
    logic aw_hs;
    logic w_hs;

    // ==========================================================
    // handshakes; no new write while a response waits
    assign s_axi_awready = !st_ff.aw_held && !st_ff.bvalid;
    assign s_axi_wready = !st_ff.w_held && !st_ff.bvalid;
    assign s_axi_arready = !st_ff.rvalid;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign wr_en = (st_ff.aw_held || aw_hs) && (st_ff.w_held || w_hs);
    assign wr_addr = st_ff.aw_held ? st_ff.awaddr : s_axi_awaddr;
    assign wr_data = st_ff.w_held ? st_ff.wdata : s_axi_wdata;
    assign wr_strb = st_ff.w_held ? st_ff.wstrb : s_axi_wstrb;
    assign rd_en = s_axi_arvalid && s_axi_arready;
    assign rd_addr = s_axi_araddr;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;

    // ==========================================================
    // next state
    always_comb
    begin
        nxt_st = st_ff;
        if (wr_en)
        begin
            // both halves present: commit and answer next cycle
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else
        begin
            // park whichever half came first
            if (aw_hs)
            begin
                nxt_st.aw_held = 1'b1;
                nxt_st.awaddr = s_axi_awaddr;
            end
            if (w_hs)
            begin
                nxt_st.w_held = 1'b1;
                nxt_st.wdata = s_axi_wdata;
                nxt_st.wstrb = s_axi_wstrb;
            end
        end
        if (st_ff.bvalid && s_axi_bready)
        begin
            nxt_st.bvalid = 1'b0;
        end
        if (rd_en)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = rd_ok ? rd_data : 32'h00000000;
            nxt_st.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (st_ff.rvalid && s_axi_rready)
        begin
            nxt_st.rvalid = 1'b0;
        end
    end

    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

endmodule : sxa_axil_slave

/* File: verif/sxa_file_model.sv */
// data register file model facing the datapath file port
`timescale 1ns/1ps
module sxa_file_model
(
    // clock
    input wire logic aclk,
    // file port
    input wire logic [6:0] file_addr,
    output logic [7:0] file_rd_data,
    input wire logic file_wr_en,
    input wire logic [7:0] file_wr_data
);
    // ==========================================================
    // storage: 128 bytes, addresses 0..127, preset by the bench
    logic [7:0] mem [0:127];

    // combinational read, valid within the execute cycle
    assign file_rd_data = mem[file_addr];

    // write back on the one-cycle strobe
    always @(posedge aclk)
    begin
        if (file_wr_en)
        begin
            mem[file_addr] <= file_wr_data;
        end
    end
endmodule : sxa_file_model

/* File: verif/testbench.sv */
// self-checking bench: AXI4-Lite master, integer model, file register partner
`timescale 1ns/1ps
module testbench;
    import sxa_pkg::*;
    // ==========================================================
    // bench signals
    logic aclk, aresetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [6:0] file_addr;
    logic [7:0] file_rd_data, file_wr_data;
    logic file_wr_en;
    int mismatches, checks, cycles;
    // model state: working register, flags {zero, digit carry, carry}
    int mw, mfl, r, a, w, lit, fv, fa, op, dest;

    // ==========================================================
    // design and far-side partner
    sxa_alu_top u_dut
    (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .file_addr(file_addr), .file_rd_data(file_rd_data), .file_wr_en(file_wr_en), .file_wr_data(file_wr_data)
    );
    sxa_file_model u_mem
    (
        .aclk(aclk), .file_addr(file_addr), .file_rd_data(file_rd_data),
        .file_wr_en(file_wr_en), .file_wr_data(file_wr_data)
    );

    // ==========================================================
    // clock, 8 ns period
    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // hang guard: counts as a mismatch
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            test_done();
        end
    end

    // ==========================================================
    // compare and report
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // closing report and verdict
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    // write: address and data offered together, ready seen mid-cycle, taken at the next edge
    task automatic wchk(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        bit aw_left, w_left, aw_hit, w_hit;
        aw_left = 1;
        w_left = 1;
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw_left || w_left)
        begin
            @(negedge aclk);
            aw_hit = aw_left && s_axi_awready;
            w_hit = w_left && s_axi_wready;
            @(posedge aclk);
            if (aw_hit) begin s_axi_awvalid <= 1'b0; aw_left = 0; end
            if (w_hit) begin s_axi_wvalid <= 1'b0; w_left = 0; end
        end
        do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
        chk("bresp", er, s_axi_bresp);
        // bready stays high: the response is taken at this edge
        @(posedge aclk);
    endtask : wchk

    // read: compare masked data and response mid-cycle, at the first falling edge with rvalid high
    task automatic rchk(input logic [7:0] ad, input logic [31:0] ed, input logic [31:0] m, input logic [1:0] er);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
        chk("rresp", er, s_axi_rresp);
        chk("rdata", ed & m, s_axi_rdata & m);
        // rready stays high: the data beat is taken at this edge
        @(posedge aclk);
    endtask : rchk

    // ==========================================================
    // main sequence
    initial
    begin
        void'($urandom(57));
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        aresetn = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // reset values, unmapped place, ignored lanes
        rchk(OFS_W_REG, 32'(RST_W_REG), 32'hFF, RESP_OKAY);
        rchk(OFS_FLAGS, 32'(RST_FLAGS), 32'h7, RESP_OKAY);
        rchk(OFS_CMD, 32'(RST_CMD), 32'hFFFFFF, RESP_OKAY);
        wchk(8'h10, 32'h5A, 4'hF, RESP_SLVERR);
        rchk(8'h10, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
        wchk(OFS_W_REG, 32'hAB, 4'hE, RESP_OKAY);
        rchk(OFS_W_REG, 32'h0, 32'hFF, RESP_OKAY);
        // every op code, both destinations, boundary addresses and zero results
        for (int i = 0; i < 48; i++)
        begin
            op = i % 8;
            dest = $urandom % 2;
            fa = (i % 3 == 0) ? 0 : (i % 3 == 1) ? 127 : $urandom % 128;
            w = $urandom % 256;
            lit = (i % 5 == 0) ? w : $urandom % 256;
            fv = (i % 5 == 0) ? w : $urandom % 256;
            mw = w;
            mfl = $urandom % 8;
            wchk(OFS_W_REG, 32'(w), 4'hF, RESP_OKAY);
            wchk(OFS_FLAGS, 32'(mfl), 4'hF, RESP_OKAY);
            u_mem.mem[fa] = 8'(fv);
            wchk(OFS_CMD, {8'h00, 8'(lit), 5'h00, 7'(fa), 1'(dest), 3'(op)}, 4'hF, RESP_OKAY);
            repeat (2) @(posedge aclk);
            case (op)
                0, 2:
                begin
                    a = (op == 0) ? lit : fv;
                    r = (a - w) & 255;
                    mfl = ((r == 0) << 2) | (((a % 16) >= (w % 16)) << 1) | (a >= w);
                end
                1, 3:
                begin
                    r = ((op == 1) ? lit : fv) ^ w;
                    mfl = (mfl & 3) | ((r == 0) << 2);
                end
                4: r = ((fv % 16) << 4) | (fv / 16);
                default: r = -1;
            endcase
            if (r >= 0)
            begin
                if (op < 2 || dest == 0) mw = r; else fv = r;
            end
            rchk(OFS_W_REG, 32'(mw), 32'hFF, RESP_OKAY);
            rchk(OFS_FLAGS, 32'(mfl), 32'h7, RESP_OKAY);
            chk("file", 32'(fv), 32'(u_mem.mem[fa]));
            if (r >= 0) rchk(OFS_STATE, 32'(r), 32'h3FF, RESP_OKAY);
            else rchk(OFS_STATE, 32'h200, 32'h300, RESP_OKAY);
        end
        // status register is read-only: the write is acknowledged and dropped
        wchk(OFS_STATE, 32'h0, 4'hF, RESP_OKAY);
        rchk(OFS_STATE, 32'h200, 32'h300, RESP_OKAY);
        test_done();
    end
endmodule : testbench
